// *** src/btc_core.sv ***
// Operation
// - branch on clear overflow jumps PC+k+1, one or two cycles, flags kept
// - interrupt-state branches jump PC+k+1 on I set or clear, flags kept
// - io bit set and clear force one io bit, two cycles, flags kept
// - rotate left through carry, updates Z C N V in one cycle
// - rotate right through carry, updates Z C N V in one cycle
// - bit-to-flag copy puts register bit into T, one cycle
// - flag-to-bit copy writes T into register bit, one cycle, flags kept
// - each flag set or clear op forces only its own flag, one cycle
// - post-increment load reads at pointer then bumps pointer, two cycles
// - pre-decrement load lowers pointer then reads there, two cycles
// - displacement load reads Y or Z plus q, pointer kept, two cycles
// - direct load reads the address in the second word, two cycles
// - post-increment store writes at pointer then bumps pointer, two cycles
// - pre-decrement store lowers pointer then writes there, two cycles
// - displacement store writes Y or Z plus q, pointer kept, two cycles
// - direct store writes the address in the second word, two cycles
// - push places a register on the stack in two cycles
// - pop returns top stack byte into a register in two cycles
// - break serves debug only and modifies no flags
`timescale 1ns/1ns
`include "btc_defs.svh"
module btc_core (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        INSTR_VALID,
    input  wire logic [15:0] INSTR,
    input  wire logic [15:0] INSTR_EXT,
    output logic             INSTR_READY,
    output logic [15:0]      PC,
    output logic [15:0]      DM_ADDR,
    output logic [7:0]       DM_WDATA,
    output logic             DM_RE,
    output logic             DM_WE,
    input  wire logic [7:0]  DM_RDATA,
    output logic [4:0]       IO_ADDR,
    output logic [7:0]       IO_WDATA,
    output logic             IO_RE,
    output logic             IO_WE,
    input  wire logic [7:0]  IO_RDATA,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [7:0]       REG_RDATA,
    output logic             DBG_BREAK
);
    import btc_pkg::*;

    btc_dp_if dp ();

    btc_regfile u_rf (.CLK(CLK), .SYS_RST(SYS_RST), .dp(dp));
    btc_status  u_st (.CLK(CLK), .SYS_RST(SYS_RST), .dp(dp));

    btc_core_s   q;
    btc_core_s   n;
    logic        take;
    logic        halted;
    logic [3:0]  nib;
    logic        is_brb;
    logic        br_hit;
    logic        is_io;
    logic        is_rol;
    logic        is_ror;
    logic        is_bfl;
    logic        is_bst;
    logic        is_bld;
    logic        is_grp;
    logic        is_dir;
    logic        is_stk;
    logic        is_ind;
    logic        is_ldd;
    logic        is_brk;
    logic        is_mem;
    logic        wr_op;
    logic        pinc;
    logic        pdec;
    logic [5:0]  q6;
    logic [7:0]  bmask;
    logic [7:0]  fmask;
    logic        sel_bit;
    logic [7:0]  rot_v;
    logic        rot_c;
    logic        rot_z;
    logic [15:0] br_tgt;
    logic [15:0] maddr;
    logic [7:0]  rsel;
    btc_ptr_e    psel;

    function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
        step16 = up ? v + 16'h0001 : v - 16'h0001;
    endfunction

    function automatic logic [7:0] rot_flags(input logic [7:0] f, input logic [7:0] r, input logic c);
        logic [7:0] o;
        o = f;
        o[`BTC_FL_C] = c;
        o[`BTC_FL_Z] = r == 8'h00;
        o[`BTC_FL_N] = r[7];
        o[`BTC_FL_V] = r[7] ^ c;
        o[`BTC_FL_S] = o[`BTC_FL_N] ^ o[`BTC_FL_V];
        rot_flags = o;
    endfunction

    assign halted = !q.run && q.st == S_IDLE;
    assign INSTR_READY = q.run && q.st == S_IDLE;
    assign take = INSTR_VALID && INSTR_READY;
    assign PC = q.pc;
    assign REG_RDATA = q.rdata;
    assign DBG_BREAK = q.brk;

    // instruction decode
    assign nib = INSTR[3:0];
    assign is_brb = INSTR[15:11] == 5'b11110;
    assign br_hit = dp.fq[INSTR[2:0]] != INSTR[10];
    assign is_io = INSTR[15:10] == 6'b100110 && !INSTR[8];
    assign is_rol = INSTR[15:10] == 6'b000111 && {INSTR[9], INSTR[3:0]} == INSTR[8:4];
    assign is_ror = INSTR[15:9] == 7'b1001010 && nib == 4'h7;
    assign is_bfl = INSTR[15:8] == 8'h94 && nib == 4'h8;
    assign is_bst = INSTR[15:9] == 7'b1111101 && !INSTR[3];
    assign is_bld = INSTR[15:9] == 7'b1111100 && !INSTR[3];
    assign is_grp = INSTR[15:10] == 6'b100100;
    assign is_dir = is_grp && nib == 4'h0;
    assign is_stk = is_grp && nib == 4'hf;
    assign is_ind = is_grp && nib[1:0] != 2'b11 && (nib[3:2] == 2'b11 || (!nib[2] && nib[1:0] != 2'b00));
    assign is_ldd = INSTR[15:14] == 2'b10 && !INSTR[12];
    assign is_brk = INSTR == `BTC_OP_BREAK;
    assign is_mem = is_dir || is_stk || is_ind || is_ldd;
    assign wr_op = INSTR[9];
    assign pinc = is_ind && nib[1:0] == 2'b01;
    assign pdec = is_ind && nib[1:0] == 2'b10;
    assign q6 = {INSTR[13], INSTR[11:10], INSTR[2:0]};
    assign bmask = 8'h01 << INSTR[2:0];
    assign fmask = 8'h01 << INSTR[6:4];
    assign sel_bit = dp.rda[INSTR[2:0]];
    assign rot_v = is_rol ? {dp.rda[6:0], dp.fq[`BTC_FL_C]} : {dp.fq[`BTC_FL_C], dp.rda[7:1]};
    assign rot_c = is_rol ? dp.rda[7] : dp.rda[0];
    assign rot_z = rot_v == 8'h00;
    assign br_tgt = q.pc + {{9{INSTR[9]}}, INSTR[9:3]} + 16'h0001;

    always_comb
    begin
        if (is_ldd)
            psel = INSTR[3] ? P_Y : P_Z;
        else if (nib[3:2] == 2'b11)
            psel = P_X;
        else if (nib[3])
            psel = P_Y;
        else
            psel = P_Z;
        if (is_dir)
            maddr = INSTR_EXT;
        else if (is_stk)
            maddr = wr_op ? q.sp : step16(q.sp, 1'b1);
        else if (pdec)
            maddr = step16(dp.pword, 1'b0);
        else if (is_ldd)
            maddr = dp.pword + {10'h000, q6};
        else
            maddr = dp.pword;
        if (REG_ADDR <= `BTC_A_GPR_MAX)
            rsel = dp.rdb;
        else if (REG_ADDR == `BTC_A_FLAGS)
            rsel = dp.fq;
        else if (REG_ADDR == `BTC_A_PCL)
            rsel = q.pc[7:0];
        else if (REG_ADDR == `BTC_A_PCH)
            rsel = q.pc[15:8];
        else if (REG_ADDR == `BTC_A_SPL)
            rsel = q.sp[7:0];
        else if (REG_ADDR == `BTC_A_SPH)
            rsel = q.sp[15:8];
        else if (REG_ADDR == `BTC_A_CTRL)
            rsel = {7'h00, q.run};
        else if (REG_ADDR == `BTC_A_STAT)
            rsel = {6'h00, q.brk, q.st != S_IDLE};
        else
            rsel = 8'h00;
    end

    always_comb
    begin
        n = q;
        n.rdata = REG_RD ? rsel : 8'h00;
        dp.ra = INSTR[8:4];
        dp.rb = REG_ADDR[4:0];
        dp.we = 1'b0;
        dp.wa = INSTR[8:4];
        dp.wd = rot_v;
        dp.psel = psel;
        dp.pwe = 1'b0;
        dp.pwd = step16(dp.pword, pinc);
        dp.fwe = 1'b0;
        dp.fd = dp.fq;
        DM_RE = 1'b0;
        DM_WE = 1'b0;
        DM_ADDR = maddr;
        DM_WDATA = dp.rda;
        IO_RE = 1'b0;
        IO_WE = 1'b0;
        IO_ADDR = INSTR[7:3];
        IO_WDATA = q.setb ? (IO_RDATA | q.mask) : (IO_RDATA & ~q.mask);
        // port writes come first so that a break in the same cycle wins
        if (REG_WR)
        begin
            if (REG_ADDR == `BTC_A_CTRL)
                n.run = REG_WDATA[`BTC_CTRL_RUN];
            else if (REG_ADDR == `BTC_A_STAT)
            begin
                if (REG_WDATA[`BTC_STAT_BRK])
                    n.brk = 1'b0;
            end
            else if (halted)
            begin
                if (REG_ADDR <= `BTC_A_GPR_MAX)
                begin
                    dp.we = 1'b1;
                    dp.wa = REG_ADDR[4:0];
                    dp.wd = REG_WDATA;
                end
                else if (REG_ADDR == `BTC_A_FLAGS)
                begin
                    dp.fwe = 1'b1;
                    dp.fd = REG_WDATA;
                end
                else if (REG_ADDR == `BTC_A_PCL)
                    n.pc[7:0] = REG_WDATA;
                else if (REG_ADDR == `BTC_A_PCH)
                    n.pc[15:8] = REG_WDATA;
                else if (REG_ADDR == `BTC_A_SPL)
                    n.sp[7:0] = REG_WDATA;
                else if (REG_ADDR == `BTC_A_SPH)
                    n.sp[15:8] = REG_WDATA;
            end
        end
        case (q.st)
            S_LOAD:
            begin
                dp.we = 1'b1;
                dp.wa = q.dst;
                dp.wd = DM_RDATA;
                n.st = S_IDLE;
            end
            S_IOW:
            begin
                IO_WE = 1'b1;
                IO_ADDR = q.ioa;
                n.st = S_IDLE;
            end
            S_WAIT:
                n.st = S_IDLE;
            default:
            begin
                if (take)
                begin
                    n.pc = step16(q.pc, 1'b1);
                    if (is_brb)
                    begin
                        if (br_hit)
                        begin
                            n.pc = br_tgt;
                            n.st = S_WAIT;
                        end
                    end
                    else if (is_io)
                    begin
                        IO_RE = 1'b1;
                        n.ioa = INSTR[7:3];
                        n.mask = bmask;
                        n.setb = INSTR[9];
                        n.st = S_IOW;
                    end
                    else if (is_rol || is_ror)
                    begin
                        dp.we = 1'b1;
                        dp.fwe = 1'b1;
                        dp.fd = rot_flags(dp.fq, rot_v, rot_c);
                    end
                    else if (is_bst)
                    begin
                        dp.fwe = 1'b1;
                        dp.fd[`BTC_FL_T] = sel_bit;
                    end
                    else if (is_bld)
                    begin
                        dp.we = 1'b1;
                        dp.wd = dp.fq[`BTC_FL_T] ? (dp.rda | bmask) : (dp.rda & ~bmask);
                    end
                    else if (is_bfl)
                    begin
                        dp.fwe = 1'b1;
                        dp.fd[INSTR[6:4]] = !INSTR[7];
                    end
                    else if (is_mem)
                    begin
                        DM_RE = !wr_op;
                        DM_WE = wr_op;
                        n.dst = INSTR[8:4];
                        n.st = wr_op ? S_WAIT : S_LOAD;
                        dp.pwe = pinc || pdec;
                        if (is_stk)
                            n.sp = step16(q.sp, !wr_op);
                        if (is_dir)
                            n.pc = q.pc + 16'h0002;
                    end
                    else if (is_brk)
                    begin
                        n.brk = 1'b1;
                        n.run = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            q <= '{S_IDLE, `BTC_PC_RST, `BTC_SP_RST, 5'h00, 5'h00, 8'h00, 1'b0, `BTC_RUN_RST, 1'b0, 8'h00};
        else
            q <= n;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_take_ld;
        take && is_mem && !wr_op;
    endsequence
    sequence s_ld_done;
        q.st == S_LOAD && !INSTR_READY ##1 q.st == S_IDLE;
    endsequence
    sequence s_two_slot;
        !INSTR_READY ##1 q.st == S_IDLE;
    endsequence

    AST_BR_TAKEN: assert property (take && is_brb && br_hit |=> PC == $past(br_tgt) && dp.fq == $past(dp.fq) ##0 s_two_slot)
        else $error("taken branch wrong target or length");
    AST_BR_NOT: assert property (take && is_brb && !br_hit |=> PC == $past(PC) + 16'h0001 && dp.fq == $past(dp.fq))
        else $error("untaken branch moved wrongly");
    AST_IO_RMW: assert property (take && is_io |-> IO_RE ##1 IO_WE && IO_ADDR == $past(IO_ADDR) && dp.fq == $past(dp.fq))
        else $error("io bit op not a two cycle read modify write");
    AST_ROL: assert property (take && is_rol |=> dp.fq[`BTC_FL_C] == $past(rot_c) && dp.fq[`BTC_FL_Z] == $past(rot_z))
        else $error("rotate left flags wrong");
    AST_ROR: assert property (take && is_ror |-> dp.we && dp.wd[7] == dp.fq[`BTC_FL_C] ##1 dp.fq[`BTC_FL_C] == $past(rot_c))
        else $error("rotate right result or carry wrong");
    AST_BST: assert property (take && is_bst |=> dp.fq[`BTC_FL_T] == $past(sel_bit) && dp.fq[5:0] == $past(dp.fq[5:0]))
        else $error("bit to flag copy wrong");
    AST_BLD: assert property (take && is_bld |-> dp.we && dp.wd[INSTR[2:0]] == dp.fq[`BTC_FL_T] ##1 dp.fq == $past(dp.fq))
        else $error("flag to bit copy wrong");
    AST_BFL: assert property (take && is_bfl |=> ((dp.fq ^ $past(dp.fq)) & ~$past(fmask)) == 8'h00 && ((dp.fq & $past(fmask)) != 8'h00) != $past(INSTR[7]))
        else $error("flag op touched the wrong flag");
    AST_LD_TWO: assert property (s_take_ld |-> DM_RE ##1 s_ld_done)
        else $error("load did not finish in two cycles");
    AST_PREDEC: assert property (take && pdec |-> DM_ADDR == dp.pword - 16'h0001 && dp.pwe && dp.pwd == DM_ADDR)
        else $error("pre-decrement address wrong");
    AST_DISP: assert property (take && is_ldd |-> DM_ADDR == dp.pword + {10'h000, q6} && !dp.pwe)
        else $error("displacement address wrong or pointer moved");
    AST_DIRECT: assert property (take && is_dir |-> DM_ADDR == INSTR_EXT ##1 PC == $past(PC) + 16'h0002)
        else $error("direct access address or program counter wrong");
    AST_POSTINC: assert property (take && pinc |-> DM_ADDR == dp.pword && dp.pwd == dp.pword + 16'h0001)
        else $error("post-increment address wrong");
    AST_ST_TWO: assert property (take && is_mem && wr_op |-> DM_WE && !DM_RE ##1 s_two_slot)
        else $error("store did not take two cycles");
    AST_ST_FLAGS: assert property (take && is_ldd && wr_op |-> ##2 dp.fq == $past(dp.fq, 2))
        else $error("store changed flags");
    AST_DIR_ST: assert property (take && is_dir && wr_op |-> DM_WE && DM_WDATA == dp.rda)
        else $error("direct store data wrong");
    AST_PUSH: assert property (take && is_stk && wr_op |-> DM_ADDR == q.sp ##1 q.sp == $past(q.sp) - 16'h0001)
        else $error("push stack pointer wrong");
    AST_POP: assert property (take && is_stk && !wr_op |-> DM_ADDR == q.sp + 16'h0001 ##1 q.sp == $past(DM_ADDR))
        else $error("pop stack pointer wrong");
    AST_BRK: assert property (take && is_brk |=> DBG_BREAK && !INSTR_READY && dp.fq == $past(dp.fq))
        else $error("break did not halt or changed flags");
endmodule

// *** pkg/btc_defs.svh ***
`ifndef BTC_DEFS_SVH
`define BTC_DEFS_SVH

// status flag bit positions
`define BTC_FL_C 3'd0
`define BTC_FL_Z 3'd1
`define BTC_FL_N 3'd2
`define BTC_FL_V 3'd3
`define BTC_FL_S 3'd4
`define BTC_FL_H 3'd5
`define BTC_FL_T 3'd6
`define BTC_FL_I 3'd7

// reset values
`define BTC_FLAGS_RST 8'h00
`define BTC_PC_RST    16'h0000
`define BTC_SP_RST    16'h00ff
`define BTC_RUN_RST   1'b1
`define BTC_RF_RST    8'h00

// pointer pairs, low byte index
`define BTC_X_LO 5'd26
`define BTC_Y_LO 5'd28
`define BTC_Z_LO 5'd30

// register port map
`define BTC_A_GPR_MAX 8'h1f
`define BTC_A_FLAGS   8'h20
`define BTC_A_PCL     8'h21
`define BTC_A_PCH     8'h22
`define BTC_A_SPL     8'h23
`define BTC_A_SPH     8'h24
`define BTC_A_CTRL    8'h25
`define BTC_A_STAT    8'h26

// control and status fields
`define BTC_CTRL_RUN  3'd0
`define BTC_STAT_BUSY 3'd0
`define BTC_STAT_BRK  3'd1

// opcodes with a fixed pattern
`define BTC_OP_BREAK  16'h9598

`endif

// *** pkg/btc_pkg.sv ***
package btc_pkg;

    typedef enum logic [1:0] {S_IDLE, S_LOAD, S_IOW, S_WAIT} btc_state_e;

    typedef enum logic [1:0] {P_X, P_Y, P_Z} btc_ptr_e;

    typedef struct packed {
        btc_state_e  st;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [4:0]  dst;
        logic [4:0]  ioa;
        logic [7:0]  mask;
        logic        setb;
        logic        run;
        logic        brk;
        logic [7:0]  rdata;
    } btc_core_s;

    typedef struct packed {
        logic [31:0][7:0] r;
    } btc_rf_s;

    typedef struct packed {
        logic [7:0] f;
    } btc_st_s;

endpackage

// *** pkg/btc_dp_if.sv ***
`timescale 1ns/1ns
interface btc_dp_if;
    logic [4:0]       ra;
    logic [7:0]       rda;
    logic [4:0]       rb;
    logic [7:0]       rdb;
    logic             we;
    logic [4:0]       wa;
    logic [7:0]       wd;
    btc_pkg::btc_ptr_e psel;
    logic [15:0]      pword;
    logic             pwe;
    logic [15:0]      pwd;
    logic             fwe;
    logic [7:0]       fd;
    logic [7:0]       fq;

    modport core (output ra, rb, we, wa, wd, psel, pwe, pwd, fwe, fd, input rda, rdb, pword, fq);
    modport rf   (input ra, rb, we, wa, wd, psel, pwe, pwd, output rda, rdb, pword);
    modport st   (input fwe, fd, output fq);
endinterface

// *** src/btc_regfile.sv ***
`timescale 1ns/1ns
`include "btc_defs.svh"
module btc_regfile (
    input wire logic CLK,
    input wire logic SYS_RST,
    btc_dp_if.rf     dp
);
    import btc_pkg::*;

    btc_rf_s    q;
    btc_rf_s    next_q;
    logic [4:0] plo;
    logic [4:0] phi;

    always_comb
    begin
        if (dp.psel == P_X)
            plo = `BTC_X_LO;
        else if (dp.psel == P_Y)
            plo = `BTC_Y_LO;
        else
            plo = `BTC_Z_LO;
        phi = plo | 5'h01;
        dp.rda = q.r[dp.ra];
        dp.rdb = q.r[dp.rb];
        dp.pword = {q.r[phi], q.r[plo]};
        next_q = q;
        // pointer step first so a byte write to the same register wins
        if (dp.pwe)
        begin
            next_q.r[plo] = dp.pwd[7:0];
            next_q.r[phi] = dp.pwd[15:8];
        end
        if (dp.we)
            next_q.r[dp.wa] = dp.wd;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            q <= '{r: '{default: `BTC_RF_RST}};
        else
            q <= next_q;
    end
endmodule

// *** src/btc_status.sv ***
`timescale 1ns/1ns
`include "btc_defs.svh"
module btc_status (
    input wire logic CLK,
    input wire logic SYS_RST,
    btc_dp_if.st     dp
);
    import btc_pkg::*;

    btc_st_s q;
    btc_st_s next_q;

    always_comb
    begin
        next_q = q;
        if (dp.fwe)
            next_q.f = dp.fd;
        dp.fq = q.f;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            q <= '{f: `BTC_FLAGS_RST};
        else
            q <= next_q;
    end
endmodule

// *** tb/btc_mem_model.sv ***
`timescale 1ns/1ns
module btc_mem_model (
    input  wire logic        CLK,
    input  wire logic [15:0] DM_ADDR,
    input  wire logic [7:0]  DM_WDATA,
    input  wire logic        DM_RE,
    input  wire logic        DM_WE,
    output logic      [7:0]  DM_RDATA,
    input  wire logic [4:0]  IO_ADDR,
    input  wire logic [7:0]  IO_WDATA,
    input  wire logic        IO_RE,
    input  wire logic        IO_WE,
    output logic      [7:0]  IO_RDATA
);
    logic [7:0] mem [256];
    logic [7:0] io  [32];

    initial
    begin
        DM_RDATA = 8'h00;
        IO_RDATA = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
        for (int i = 0; i < 32; i++)
            io[i] = 8'(i) ^ 8'ha5;
    end

    // read data stands one cycle, then flips every cycle so stale data never matches
    always @(posedge CLK)
    begin
        DM_RDATA <= DM_RE ? mem[DM_ADDR[7:0]] : ~DM_RDATA;
        IO_RDATA <= IO_RE ? io[IO_ADDR] : ~IO_RDATA;
        if (DM_WE)
            mem[DM_ADDR[7:0]] <= DM_WDATA;
        if (IO_WE)
            io[IO_ADDR] <= IO_WDATA;
    end
endmodule

// *** tb/cpu_bit_transfer_control_ops_tb.sv ***
`timescale 1ns/1ns
module cpu_bit_transfer_control_ops_tb;
    import btc_pkg::*;
    logic        CLK, SYS_RST, INSTR_VALID, INSTR_READY, DM_RE, DM_WE, IO_RE, IO_WE;
    logic        REG_WR, REG_RD, DBG_BREAK, rd_q;
    logic [15:0] INSTR, INSTR_EXT, PC, DM_ADDR, pc;
    logic [7:0]  DM_WDATA, DM_RDATA, IO_WDATA, IO_RDATA, REG_ADDR, REG_WDATA, REG_RDATA;
    logic [7:0]  a, b, x, fl, iov;
    logic [4:0]  IO_ADDR, ia;
    logic [2:0]  ib;
    logic [7:0]  rq [$];
    logic [23:0] wq [$];
    int          n_mismatch, samples_checked, seed, i;

    btc_core i_btc_core (.CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
        .INSTR_EXT(INSTR_EXT), .INSTR_READY(INSTR_READY), .PC(PC), .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA),
        .DM_RE(DM_RE), .DM_WE(DM_WE), .DM_RDATA(DM_RDATA), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
        .IO_RE(IO_RE), .IO_WE(IO_WE), .IO_RDATA(IO_RDATA), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DBG_BREAK(DBG_BREAK));

    btc_mem_model i_btc_mem_model (.CLK(CLK), .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA), .DM_RE(DM_RE),
        .DM_WE(DM_WE), .DM_RDATA(DM_RDATA), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_RE(IO_RE),
        .IO_WE(IO_WE), .IO_RDATA(IO_RDATA));

    function automatic logic [7:0] mp(input logic [7:0] ad);
        return ad ^ 8'h5a;
    endfunction

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp24(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t write got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
        REG_ADDR  <= ad;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic reg_rd(input logic [7:0] ad, input logic [7:0] exp);
        rq.push_back(exp);
        REG_ADDR <= ad;
        REG_RD   <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(posedge CLK);
    endtask

    // cyc is the number of cycles ready stays away after the take, plus one
    task automatic issue(input logic [15:0] op, input logic [15:0] ext, input logic [7:0] cyc,
                         input logic [15:0] dpc);
        logic [7:0] n;
        n = 8'h00;
        INSTR       <= op;
        INSTR_EXT   <= ext;
        INSTR_VALID <= 1'b1;
        do @(posedge CLK); while (INSTR_READY !== 1'b1);
        INSTR_VALID <= 1'b0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (INSTR_READY !== 1'b1 && n < 8'h08);
        cmp8(n, cyc);
        pc = pc + dpc;
        cmp24({8'h00, PC}, {8'h00, pc});
    endtask

    task automatic end_sim;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge CLK)
    begin
        rd_q <= REG_RD;
        if (rd_q === 1'b1)
            cmp8(REG_RDATA, rq.pop_front());
        if (DM_WE === 1'b1)
            cmp24({DM_ADDR, DM_WDATA}, wq.pop_front());
        if (IO_WE === 1'b1)
            cmp24({11'h000, IO_ADDR, IO_WDATA}, wq.pop_front());
    end

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        {INSTR_VALID, REG_WR, REG_RD, SYS_RST} = 4'h1;
        {INSTR, INSTR_EXT, REG_ADDR, REG_WDATA} = 48'h0;
        seed = 86;
        pc = 16'h0000;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        reg_rd(8'h20, 8'h00);
        reg_rd(8'h23, 8'hff);
        reg_rd(8'h80, 8'h00);
        reg_wr(8'h05, 8'h33);
        reg_rd(8'h05, 8'h00);
        reg_wr(8'h25, 8'h00);
        a = $random(seed);
        b = $random(seed);
        fl = 8'h01;
        reg_wr(8'h10, a);
        reg_wr(8'h11, b);
        reg_wr(8'h1a, 8'h40);
        reg_wr(8'h1c, 8'h50);
        reg_wr(8'h1e, 8'h60);
        reg_wr(8'h20, fl);
        reg_wr(8'h25, 8'h01);
        x = {a[6:0], fl[0]};
        fl = {fl[7:5], a[7], x[7] ^ a[7], x[7], x == 8'h00, a[7]};
        issue(16'h1f00, 16'h0000, 8'h01, 16'h0001);
        reg_rd(8'h10, x);
        reg_rd(8'h20, fl);
        a = {fl[0], x[7:1]};
        fl = {fl[7:5], x[0], a[7] ^ x[0], a[7], a == 8'h00, x[0]};
        issue(16'h9507, 16'h0000, 8'h01, 16'h0001);
        reg_rd(8'h10, a);
        reg_rd(8'h20, fl);
        fl[6] = a[3];
        issue(16'hfb03, 16'h0000, 8'h01, 16'h0001);
        reg_rd(8'h20, fl);
        b[5] = fl[6];
        issue(16'hf915, 16'h0000, 8'h01, 16'h0001);
        reg_rd(8'h11, b);
        reg_rd(8'h20, fl);
        for (i = 0; i < 8; i++)
        begin
            issue(16'h9408 | 16'(i << 4), 16'h0000, 8'h01, 16'h0001);
            fl[i] = 1'b1;
            reg_rd(8'h20, fl);
            issue(16'h9488 | 16'(i << 4), 16'h0000, 8'h01, 16'h0001);
            fl[i] = 1'b0;
            reg_rd(8'h20, fl);
        end
        issue(16'hf42b, 16'h0000, 8'h02, 16'h0006);
        issue(16'hf41f, 16'h0000, 8'h02, 16'h0004);
        issue(16'hf01f, 16'h0000, 8'h01, 16'h0001);
        issue(16'h9478, 16'h0000, 8'h01, 16'h0001);
        issue(16'hf01f, 16'h0000, 8'h02, 16'h0004);
        issue(16'hf41f, 16'h0000, 8'h01, 16'h0001);
        issue(16'h9438, 16'h0000, 8'h01, 16'h0001);
        issue(16'hf42b, 16'h0000, 8'h01, 16'h0001);
        issue(16'h94b8, 16'h0000, 8'h01, 16'h0001);
        issue(16'hf7e3, 16'h0000, 8'h02, 16'hfffd);
        fl = 8'h80;
        reg_rd(8'h20, fl);
        reg_rd(8'h21, pc[7:0]);
        reg_rd(8'h22, pc[15:8]);
        issue(16'h900d, 16'h0000, 8'h02, 16'h0001);
        issue(16'h901a, 16'h0000, 8'h02, 16'h0001);
        issue(16'h8025, 16'h0000, 8'h02, 16'h0001);
        issue(16'h9030, 16'h0077, 8'h02, 16'h0002);
        reg_rd(8'h00, mp(8'h40));
        reg_rd(8'h1a, 8'h41);
        reg_rd(8'h01, mp(8'h4f));
        reg_rd(8'h1c, 8'h4f);
        reg_rd(8'h02, mp(8'h65));
        reg_rd(8'h1e, 8'h60);
        reg_rd(8'h03, mp(8'h77));
        wq.push_back({16'h0041, a});
        issue(16'h930d, 16'h0000, 8'h02, 16'h0001);
        wq.push_back({16'h005f, b});
        issue(16'h9312, 16'h0000, 8'h02, 16'h0001);
        wq.push_back({16'h0052, mp(8'h40)});
        issue(16'h820b, 16'h0000, 8'h02, 16'h0001);
        wq.push_back({16'h0090, mp(8'h4f)});
        issue(16'h9210, 16'h0090, 8'h02, 16'h0002);
        wq.push_back({16'h00ff, mp(8'h65)});
        issue(16'h922f, 16'h0000, 8'h02, 16'h0001);
        reg_rd(8'h23, 8'hfe);
        issue(16'h904f, 16'h0000, 8'h02, 16'h0001);
        reg_rd(8'h04, mp(8'h65));
        reg_rd(8'h23, 8'hff);
        reg_rd(8'h1a, 8'h42);
        reg_rd(8'h1e, 8'h5f);
        reg_rd(8'h1c, 8'h4f);
        ia = $random(seed);
        ib = $random(seed);
        iov = ({3'h0, ia} ^ 8'ha5) | (8'h01 << ib);
        wq.push_back({11'h000, ia, iov});
        issue(16'h9a00 | {8'h00, ia, ib}, 16'h0000, 8'h02, 16'h0001);
        iov = iov & ~(8'h01 << ib);
        wq.push_back({11'h000, ia, iov});
        issue(16'h9800 | {8'h00, ia, ib}, 16'h0000, 8'h02, 16'h0001);
        reg_rd(8'h20, fl);
        issue(16'h9598, 16'h0000, 8'h08, 16'h0001);
        cmp8({7'h00, DBG_BREAK}, 8'h01);
        reg_rd(8'h26, 8'h02);
        reg_rd(8'h20, fl);
        reg_wr(8'h26, 8'h02);
        reg_rd(8'h26, 8'h00);
        reg_wr(8'h05, 8'h33);
        reg_rd(8'h05, 8'h33);
        reg_wr(8'h24, 8'h01);
        reg_rd(8'h24, 8'h01);
        reg_rd(8'h25, 8'h00);
        reg_wr(8'h25, 8'h01);
        // second reset in mid-run must bring back the reset state
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        cmp24({8'h00, PC}, 24'h000000);
        reg_rd(8'h05, 8'h00);
        reg_rd(8'h24, 8'h00);
        reg_rd(8'h25, 8'h01);
        reg_rd(8'h26, 8'h00);
        repeat (4) @(posedge CLK);
        // every noted expectation must have been met by a result
        cmp8(8'(rq.size() + wq.size()), 8'h00);
        end_sim();
    end
endmodule
